//--- serial_port_defs.svh
// offsets, field positions, reset values and counts of the serial control block
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
// register byte addresses
`define SERIAL_CONTROL_TWO_OFF 8'h00
`define SERIAL_CONFIG_OFF 8'h04
`define SERIAL_STATUS_OFF 8'h08
// serial_control_two fields
`define TX_EMPTY_IRQ_EN_BIT 7
`define TX_DONE_IRQ_EN_BIT 6
`define RX_FULL_IRQ_EN_BIT 5
`define IDLE_LINE_IRQ_EN_BIT 4
`define TRANSMITTER_ON_BIT 3
`define RECEIVER_ON_BIT 2
`define RECEIVER_STANDBY_BIT 1
`define SEND_BREAK_BIT 0
// serial_config fields
`define LOOP_SELECT_BIT 0
`define RECEIVER_SOURCE_SELECT_BIT 1
`define NINE_BIT_MODE_BIT 2
`define WAKE_SELECT_BIT 3
`define LONG_BREAK_SELECT_BIT 4
`define SINGLE_WIRE_DIRECTION_BIT 5
// reset values
`define SERIAL_CONTROL_TWO_RST 8'h00
`define SERIAL_CONFIG_RST 8'h00
// character lengths in bit times
`define CHAR_BITS_EIGHT 4'hA
`define CHAR_BITS_NINE 4'hB
`define LONG_BREAK_EXTRA 4'h3
`endif

//--- serial_port_pkg.sv
// types shared by the serial control block
package serial_port_pkg;
    typedef enum logic [1:0] {
        SEQ_QUIET = 2'b00,
        SEQ_IDLE_CHAR = 2'b01,
        SEQ_BREAK_CHAR = 2'b10
    } seq_state_t;
endpackage

//--- serial_control_two.sv
// second control register of the serial port with its pin, break and wakeup logic
`timescale 1ns/1ps
`include "serial_port_defs.svh"

// What this block does
// - register readable and writable at any time
// - bit 7 gates transmit-empty interrupt
// - bit 6 gates transmit-complete interrupt
// - bit 5 gates receive-full interrupt
// - bit 4 gates idle-line interrupt
// - bit 3 runs transmitter, drives transmit pin
// - single-wire: direction bit steers shared pin
// - transmitter off-then-on mid-send queues idle
// - pin held until pending characters finish
// - bit 2 receiver on, else pin released
// - loop select always releases receive pin
// - bit 1 puts receiver in standby
// - wake on idle line or set MSB
// - wakeup detection clears standby bit itself
// - writing 1 then 0 queues one break
// - break repeats while bit stays set and bit 3 is on
// - a second break may be queued
// - nine-bit mode for both directions
// - loop feeds transmitter into receiver internally
module serial_control_two (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // status flags from the data path
    input wire logic tx_buffer_empty_flag_i,
    input wire logic tx_complete_flag_i,
    input wire logic rx_buffer_full_flag_i,
    input wire logic idle_line_flag_i,
    // transmit shifter and bit rate
    input wire logic bit_tick_i,
    input wire logic tx_shift_busy_i,
    input wire logic tx_shift_bit_i,
    // receiver wakeup detectors
    input wire logic wake_idle_seen_i,
    input wire logic wake_msb_seen_i,
    // pins
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe_n_o,
    input wire logic rxd_i,
    output logic rxd_pin_owned_o,
    // controls to the data path
    output logic transmitter_on_o,
    output logic receiver_on_o,
    output logic receiver_standby_o,
    output logic nine_bit_mode_o,
    output logic rx_line_o,
    output logic irq_o
);

    logic [7:0] serial_control_two_reg, serial_config_reg, wdat;
    logic [31:0] rdata_reg;
    logic [3:0] bits_left_reg, char_len, break_len, irq_mask;
    serial_port_pkg::seq_state_t seq_reg;
    logic ack_reg, idle_pending_reg, break_pending_reg, tx_own_reg, txd_reg;
    logic rx_line_reg, irq_reg, bus_req, wr_ctl, wr_cfg, loop_select, receiver_source_select;
    logic single_wire_direction, wake_select, tx_line, seq_busy, slot_free, wake_hit;

    // bus decode; a new request is seen only while ack is low
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wdat = wb_dat_i[7:0];
    assign wr_ctl = bus_req && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == `SERIAL_CONTROL_TWO_OFF);
    assign wr_cfg = bus_req && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == `SERIAL_CONFIG_OFF);

    // configuration fields
    assign loop_select = serial_config_reg[`LOOP_SELECT_BIT];
    assign receiver_source_select = serial_config_reg[`RECEIVER_SOURCE_SELECT_BIT];
    assign single_wire_direction = serial_config_reg[`SINGLE_WIRE_DIRECTION_BIT];
    assign wake_select = serial_config_reg[`WAKE_SELECT_BIT];

    // character and break length in bit times
    // break length select
    assign char_len = serial_config_reg[`NINE_BIT_MODE_BIT] ? `CHAR_BITS_NINE
        : `CHAR_BITS_EIGHT;
    assign break_len = serial_config_reg[`LONG_BREAK_SELECT_BIT]
        ? 4'(char_len + `LONG_BREAK_EXTRA) : char_len;

    // single-cycle ack, answered one edge after the request
    // no activity interlock
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= bus_req;
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= 32'h0000_0000;
        else if (bus_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `SERIAL_CONTROL_TWO_OFF: rdata_reg <= {24'h00_0000, serial_control_two_reg};
                `SERIAL_CONFIG_OFF: rdata_reg <= {24'h00_0000, serial_config_reg};
                `SERIAL_STATUS_OFF: rdata_reg <= {25'h000_0000, irq_reg, seq_busy,
                    tx_own_reg, idle_line_flag_i, rx_buffer_full_flag_i,
                    tx_complete_flag_i, tx_buffer_empty_flag_i};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // configuration register, plain storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_config_reg <= `SERIAL_CONFIG_RST;
        else if (wr_cfg)
            serial_config_reg <= {2'b00, wdat[5:0]};
    end

    // wakeup condition picked by wake select
    // idle line or address mark
    assign wake_hit = wake_select ? wake_msb_seen_i : wake_idle_seen_i;

    // control register; a software write beats a same-cycle wakeup
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_control_two_reg <= `SERIAL_CONTROL_TWO_RST;
        else if (wr_ctl)
            serial_control_two_reg <= wdat;
        else if (wake_hit)
            serial_control_two_reg[`RECEIVER_STANDBY_BIT] <= 1'b0;
    end

    // queued idle: transmitter turned back on while characters are still going
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            idle_pending_reg <= 1'b0;
        else if (wr_ctl && wdat[`TRANSMITTER_ON_BIT]
            && !serial_control_two_reg[`TRANSMITTER_ON_BIT]
            && (tx_shift_busy_i || seq_busy || tx_own_reg))
            idle_pending_reg <= 1'b1;
        else if (slot_free && !break_pending_reg
            && !(serial_control_two_reg[`SEND_BREAK_BIT] && transmitter_on_o))
            idle_pending_reg <= 1'b0;
    end

    // queued break: a 0-to-1 write is remembered even if cleared at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            break_pending_reg <= 1'b0;
        else if (wr_ctl && wdat[`SEND_BREAK_BIT]
            && !serial_control_two_reg[`SEND_BREAK_BIT])
            break_pending_reg <= 1'b1;
        else if (slot_free)
            break_pending_reg <= 1'b0;
    end

    // a slot opens once the shifter and sequencer are both quiet
    assign seq_busy = (seq_reg != serial_port_pkg::SEQ_QUIET);
    assign slot_free = !seq_busy && !tx_shift_busy_i
        && (break_pending_reg || idle_pending_reg
        || (serial_control_two_reg[`SEND_BREAK_BIT] && transmitter_on_o));

    // idle and break character sequencer, paced by the bit tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seq_reg <= serial_port_pkg::SEQ_QUIET;
            bits_left_reg <= 4'h0;
        end
        else
        begin
            unique case (seq_reg)
                serial_port_pkg::SEQ_QUIET:
                begin
                    if (slot_free && (break_pending_reg
                        || (serial_control_two_reg[`SEND_BREAK_BIT] && transmitter_on_o)))
                    begin
                        seq_reg <= serial_port_pkg::SEQ_BREAK_CHAR;
                        bits_left_reg <= break_len;
                    end
                    else if (slot_free)
                    begin
                        seq_reg <= serial_port_pkg::SEQ_IDLE_CHAR;
                        bits_left_reg <= char_len;
                    end
                end
                serial_port_pkg::SEQ_IDLE_CHAR, serial_port_pkg::SEQ_BREAK_CHAR:
                begin
                    if (bit_tick_i)
                    begin
                        bits_left_reg <= 4'(bits_left_reg - 4'h1);
                        if (bits_left_reg == 4'h1)
                            seq_reg <= serial_port_pkg::SEQ_QUIET;
                    end
                end
                default:
                    seq_reg <= serial_port_pkg::SEQ_QUIET;
            endcase
        end
    end

    // transmitter serial output before the pin
    assign tx_line = (seq_reg == serial_port_pkg::SEQ_BREAK_CHAR) ? 1'b0
        : (seq_reg == serial_port_pkg::SEQ_IDLE_CHAR) ? 1'b1
        : tx_shift_busy_i ? tx_shift_bit_i : 1'b1;

    // pin ownership outlives the enable until queued work drains
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_own_reg <= 1'b0;
        else
            tx_own_reg <= serial_control_two_reg[`TRANSMITTER_ON_BIT] || seq_busy
                || tx_shift_busy_i || break_pending_reg || idle_pending_reg;
    end

    // pin drive; single-wire receive lets the pin float back as input
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            txd_reg <= 1'b1;
            txd_oe_n_o <= 1'b1;
        end
        else
        begin
            txd_reg <= tx_line;
            txd_oe_n_o <= !(tx_own_reg && !(loop_select && receiver_source_select
                && !single_wire_direction));
        end
    end
    assign txd_o = txd_reg;

    // receiver source: pin, internal loop or shared transmit pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rx_line_reg <= 1'b1;
        else if (loop_select)
            rx_line_reg <= receiver_source_select ? txd_i : tx_line;
        else
            rx_line_reg <= rxd_i;
    end
    assign rx_line_o = rx_line_reg;

    assign rxd_pin_owned_o = serial_control_two_reg[`RECEIVER_ON_BIT] && !loop_select;

    // controls handed to the shifters
    // standby control out
    assign transmitter_on_o = serial_control_two_reg[`TRANSMITTER_ON_BIT];
    assign receiver_on_o = serial_control_two_reg[`RECEIVER_ON_BIT];
    assign receiver_standby_o = serial_control_two_reg[`RECEIVER_STANDBY_BIT];
    assign nine_bit_mode_o = serial_config_reg[`NINE_BIT_MODE_BIT];

    // per-flag gating, one term each
    // transmit-empty gate
    assign irq_mask = serial_control_two_reg[7:4] & {tx_buffer_empty_flag_i,
        tx_complete_flag_i, rx_buffer_full_flag_i, idle_line_flag_i};

    // single level request, registered to keep the output glitch free
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= |irq_mask;
    end
    assign irq_o = irq_reg;

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // checks on the bus, interrupt, wakeup, break and pin logic
    property p_bus_ack;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("no ack after request");
    property p_tx_empty_irq;
        @(posedge clk_i) disable iff (rst_i)
        (serial_control_two_reg[7] && tx_buffer_empty_flag_i) |=> irq_o;
    endproperty
    a_tx_empty_irq: assert property (p_tx_empty_irq) else $error("tx empty irq lost");
    property p_idle_irq_off;
        @(posedge clk_i) disable iff (rst_i)
        (serial_control_two_reg[7:4] == 4'h1 && !idle_line_flag_i) |=> !irq_o;
    endproperty
    a_idle_irq_off: assert property (p_idle_irq_off) else $error("irq without flag");
    property p_irq_merge;
        @(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == $past(|irq_mask);
    endproperty
    a_irq_merge: assert property (p_irq_merge) else $error("irq merge wrong");
    property p_wake_clear;
        @(posedge clk_i) disable iff (rst_i)
        (receiver_standby_o && wake_hit && !wr_ctl) |=> !receiver_standby_o;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("standby not cleared");
    property p_break_len;
        @(posedge clk_i) disable iff (rst_i)
        (seq_reg == serial_port_pkg::SEQ_QUIET && slot_free && break_pending_reg)
            |=> (seq_reg == serial_port_pkg::SEQ_BREAK_CHAR && bits_left_reg == $past(break_len));
    endproperty
    a_break_len: assert property (p_break_len) else $error("break length wrong");
    property p_break_low;
        @(posedge clk_i) disable iff (rst_i)
        (seq_reg == serial_port_pkg::SEQ_BREAK_CHAR) |=> !txd_o;
    endproperty
    a_break_low: assert property (p_break_low) else $error("break not low");
    property p_pin_held;
        @(posedge clk_i) disable iff (rst_i)
        (seq_busy && !(loop_select && receiver_source_select)) |-> ##2 !txd_oe_n_o;
    endproperty
    a_pin_held: assert property (p_pin_held) else $error("pin dropped early");
    property p_idle_queue;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ctl && wdat[3] && !transmitter_on_o && tx_shift_busy_i) |=> idle_pending_reg;
    endproperty
    a_idle_queue: assert property (p_idle_queue) else $error("idle not queued");
    property p_rx_release;
        @(posedge clk_i) disable iff (rst_i)
        loop_select |-> !rxd_pin_owned_o;
    endproperty
    a_rx_release: assert property (p_rx_release) else $error("rx pin kept in loop");
    c_break: cover property (@(posedge clk_i) seq_reg == serial_port_pkg::SEQ_BREAK_CHAR);
    c_idle: cover property (@(posedge clk_i) seq_reg == serial_port_pkg::SEQ_IDLE_CHAR);
    c_wake: cover property (@(posedge clk_i) receiver_standby_o && wake_hit);
    c_irq: cover property (@(posedge clk_i) $rose(irq_o));
endmodule

//--- serial_line_node.sv
// far-side serial node: idle receive line and timing of low spans on the transmit pin
`timescale 1ns/1ps
module serial_line_node (
    // clock
    input wire logic clk_i,
    // transmit pin as the port drives it
    input wire logic tx_val_i,
    input wire logic tx_oe_n_i,
    // line levels seen by both ends
    output logic txd_level_o,
    output logic rxd_o,
    // length of the last low span in clock cycles
    output logic [15:0] low_cycles_o
);
    logic [15:0] run_reg = 16'h0000;
    logic high_reg = 1'b1;

    // pull-up once the port lets go
    assign txd_level_o = tx_oe_n_i ? 1'b1 : tx_val_i;
    // receive line rests high, no frames sent
    assign rxd_o = 1'b1;

    // back-to-back breaks merge into one span
    // a single clock of high between two breaks does not end the span
    always_ff @(posedge clk_i)
    begin
        high_reg <= txd_level_o;
        if (!txd_level_o)
            run_reg <= run_reg + 16'h0001;
        else if (high_reg && run_reg != 16'h0000)
        begin
            low_cycles_o <= run_reg;
            run_reg <= 16'h0000;
        end
    end
endmodule

//--- serial_control_two_bench.sv
// self-checking bench for the serial control register block
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module serial_control_two_bench;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tick = 0;
    logic [7:0] adr = 0, v;
    logic [31:0] wdat = 0, rdat;
    logic ack, txd, oe_n, rxd, pin_lvl, owned, irq, standby;
    logic [3:0] flags = 0;
    logic [1:0] tcnt = 0;
    logic wk_idle = 0, wk_msb = 0;
    logic [3:0] ctl_out;
    logic busy = 0, sbit = 1;
    logic [15:0] low_cycles;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [7:0] cfg [4] = '{8'h01, 8'h04, 8'h10, 8'h14};
    int fail_count = 0, tests_run = 0, lo;

    serial_control_two DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .tx_buffer_empty_flag_i(flags[0]), .tx_complete_flag_i(flags[1]),
        .rx_buffer_full_flag_i(flags[2]), .idle_line_flag_i(flags[3]), .bit_tick_i(tick),
        .tx_shift_busy_i(busy), .tx_shift_bit_i(sbit), .wake_idle_seen_i(wk_idle),
        .wake_msb_seen_i(wk_msb), .txd_i(pin_lvl), .txd_o(txd), .txd_oe_n_o(oe_n),
        .rxd_i(rxd), .rxd_pin_owned_o(owned), .transmitter_on_o(ctl_out[0]),
        .receiver_on_o(ctl_out[1]), .receiver_standby_o(standby), .nine_bit_mode_o(ctl_out[2]),
        .rx_line_o(ctl_out[3]), .irq_o(irq));
    serial_line_node far_end (.clk_i(clk_i), .tx_val_i(txd), .tx_oe_n_i(oe_n),
        .txd_level_o(pin_lvl), .rxd_o(rxd), .low_cycles_o(low_cycles));

    // clock, and one bit-time pulse every fourth cycle
    initial
        forever #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        tcnt <= tcnt + 2'd1;
        tick <= (tcnt == 2'd3);
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (e !== s)
        begin
            $display("wrong value %s expected %h seen %h", what, e, s);
            fail_count++;
        end
    endtask

    // one classic cycle; entered just after an edge, waits for ack with a bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            check("ack", 1, 0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back({1'b0, 32'h0000_0000});
        wb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({1'b1, 24'h00_0000, e});
        wb(1'b0, a, 32'h0000_0000);
    endtask

    // oldest note taken whenever an ack shows; reads compare data
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[32])
                check("read data", note[31:0], rdat);
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, well beyond the roughly 1200 cycles the run needs
    initial
    begin
        #50000;
        fail_count++;
        summarize();
    end

    initial
    begin
        v = 8'($urandom(69));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`SERIAL_CONTROL_TWO_OFF, 8'h00);
        rd(`SERIAL_CONFIG_OFF, 8'h00);
        // random patterns, even while breaks and idles run
        repeat (8)
        begin
            v = 8'($urandom());
            wr(`SERIAL_CONTROL_TWO_OFF, v);
            rd(`SERIAL_CONTROL_TWO_OFF, v);
        end
        wr(`SERIAL_CONTROL_TWO_OFF, 8'h00);
        repeat (300) @(posedge clk_i);
        check("tx pin released", 1, oe_n);
        // each enable gates only its own flag
        for (int i = 0; i < 4; i++)
        begin
            flags <= 4'b0001 << i;
            wr(`SERIAL_CONTROL_TWO_OFF, 8'h80 >> i);
            repeat (2) @(posedge clk_i);
            check("irq", 1, irq);
            wr(`SERIAL_CONTROL_TWO_OFF, ~(8'h80 >> i) & 8'hF0);
            repeat (2) @(posedge clk_i);
            check("irq", 0, irq);
        end
        flags <= 4'h0;
        // receive pin ownership over loop select and receiver enable
        for (int i = 0; i < 4; i++)
        begin
            wr(`SERIAL_CONFIG_OFF, {7'h00, i[0]});
            wr(`SERIAL_CONTROL_TWO_OFF, {5'h00, i[1], 2'h0});
            check("rx pin owned", i == 2, owned);
            check("receiver on out", i[1], ctl_out[1]);
        end
        // transmit pin drive, then single-wire direction
        wr(`SERIAL_CONFIG_OFF, 8'h00);
        wr(`SERIAL_CONTROL_TWO_OFF, 8'h08);
        repeat (3) @(posedge clk_i);
        check("tx drive", 0, oe_n);
        check("transmitter on out", 1, ctl_out[0]);
        wr(`SERIAL_CONFIG_OFF, 8'h03);
        repeat (3) @(posedge clk_i);
        check("single wire in", 1, oe_n);
        wr(`SERIAL_CONFIG_OFF, 8'h23);
        repeat (3) @(posedge clk_i);
        check("single wire out", 0, oe_n);
        // wrong detector pulsed first, then the selected one; standby is checked cleared only after both
        for (int i = 0; i < 2; i++)
        begin
            wr(`SERIAL_CONFIG_OFF, i ? 8'h08 : 8'h00);
            wr(`SERIAL_CONTROL_TWO_OFF, 8'h06);
            check("standby set", 1, standby);
            wk_msb <= !i;
            wk_idle <= i;
            @(posedge clk_i);
            wk_msb <= i;
            wk_idle <= !i;
            @(posedge clk_i);
            wk_msb <= 1'b0;
            wk_idle <= 1'b0;
            rd(`SERIAL_CONTROL_TWO_OFF, 8'h04);
            check("standby cleared", 0, standby);
        end
        // one break per set-then-clear, length from mode bits
        for (int i = 0; i < 4; i++)
        begin
            wr(`SERIAL_CONFIG_OFF, cfg[i]);
            wr(`SERIAL_CONTROL_TWO_OFF, 8'h09);
            wr(`SERIAL_CONTROL_TWO_OFF, 8'h08);
            // break still running here; loopback feeds its low level to the receiver
            check("nine bit mode", cfg[i][2], ctl_out[2]);
            check("loop rx line", !cfg[i][0], ctl_out[3]);
            repeat (100) @(posedge clk_i);
            lo = (10 + cfg[i][2] + 3 * cfg[i][4]) * 4;
            check("break span", 1, low_cycles > lo - 4 && low_cycles <= lo);
        end
        // holding the bit keeps breaks coming back to back
        wr(`SERIAL_CONFIG_OFF, 8'h00);
        wr(`SERIAL_CONTROL_TWO_OFF, 8'h09);
        repeat (150) @(posedge clk_i);
        wr(`SERIAL_CONTROL_TWO_OFF, 8'h08);
        repeat (100) @(posedge clk_i);
        check("repeated breaks", 1, low_cycles > 80);
        // enable off then on during a character queues an idle; pin held meanwhile
        busy <= 1'b1;
        sbit <= 1'b0;
        wr(`SERIAL_CONTROL_TWO_OFF, 8'h00);
        check("pin held busy", 0, oe_n);
        wr(`SERIAL_CONTROL_TWO_OFF, 8'h08);
        check("shifter bit", 0, txd);
        busy <= 1'b0;
        sbit <= 1'b1;
        repeat (4) @(posedge clk_i);
        // status: sequencer busy with the idle, pin owned
        rd(`SERIAL_STATUS_OFF, 8'h30);
        summarize();
    end
endmodule
